// File: rtl/rcw_regs.svh
`ifndef RCW_REGS_SVH
`define RCW_REGS_SVH

// ********************************
// Register map (word index, byte = 4 x index)
// ********************************
`define RCW_ADDR_W 18
`define RCW_IDX_CONFIG 16'h0000
`define RCW_IDX_STATUS 16'h0001
`define RCW_IDX_CLEAR 16'hffff

// ********************************
// Fields and reset values
// ********************************
`define RCW_CFG_DISABLE 0
`define RCW_CFG_STOP_DIS 1
`define RCW_CFG_RATE 7
`define RCW_CFG_RESET 8'h00
`define RCW_STS_WDOG 0

// ********************************
// Counter shape and timing
// ********************************
`define RCW_PRE_W 12
`define RCW_CNT_W 6
`define RCW_PRE_KEEP 12'h00f
`define RCW_PRE_FAST 12'h07f
`define RCW_PRE_SLOW 12'hfff
`define RCW_RST_SLOW_CYC 32
`define RCW_POR_SLOW_CYC 4096
`define RCW_RESP_OKAY 2'b00
`define RCW_RESP_SLVERR 2'b10

`endif

// File: rtl/rcw_pkg.sv
package rcw_pkg;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0]
    {
        RCW_RUN = 2'b00,
        RCW_PULL = 2'b01
    } rcw_rst_state_t;

    // Decoded configuration bits
    typedef struct packed
    {
        logic rate_sel;
        logic stop_dis;
        logic disable_wd;
    } rcw_cfg_t;

    // Test and debug mode pins
    typedef struct packed
    {
        logic monitor_mode;
        logic irq_test_hv;
        logic rst_test_hv;
        logic break_state;
    } rcw_mode_t;

endpackage

// File: rtl/rcw_runaway_watchdog.sv
// How it works
// - 6-bit counter after 12-bit prescaler
// - rate bit picks short or long timeout
// - clear location reads reset vector low byte
// - overflow pulls reset low, sets flag
// - stop instruction clears prescaler
// - prescaler cleared 4096 slow cycles after power-up
// - internal reset clears prescaler and counter
// - reset vector fetch clears prescaler
// - disable bit stops watchdog resets
// - monitor with test voltage disables while present
// - blank-vector monitor entry disables until power-up
// - break with test voltage on reset disables
// - never raises a CPU interrupt
// - keeps counting in wait mode
// - stop gates slow clock, clears prescaler
// - stop disabled gives illegal opcode reset
// - counts on slow internal clock only
//
// Chosen here: the AXI4-Lite interface to the registers.
`include "rcw_regs.svh"

module rcw_runaway_watchdog
    import rcw_pkg::*;
#(
    parameter int PRE_W = `RCW_PRE_W,
    parameter int CNT_W = `RCW_CNT_W,
    parameter int POR_CYC = `RCW_POR_SLOW_CYC
)
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // AXI4-Lite write
    input wire logic [`RCW_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [`RCW_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Slow clock and system events
    input wire logic slow_internal_clock,
    input wire logic internal_reset,
    input wire logic vector_fetch,
    input wire logic [7:0] reset_vector_lo,
    input wire logic stop_exec,
    input wire logic stop_wake,
    input wire rcw_mode_t mode_pins,
    // Reset outputs
    output logic wdog_reset_n,
    output logic illegal_op_reset
);

    // ********************************
    // State
    // ********************************
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic [7:0] cfg_q;
    rcw_cfg_t cfg;
    logic flag_q;
    logic slow_prev_q;
    logic stop_q;
    logic mon_prev_q;
    logic mon_hv_q;
    logic blank_q;
    logic [12:0] por_cnt_q;
    logic por_done_q;
    rcw_rst_state_t rst_st_q;
    logic [4:0] pull_cnt_q;
    logic aw_got_q;
    logic w_got_q;
    logic [`RCW_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic illegal_q;
    logic rst_n_q;

    // Word index match on a byte address
    function automatic logic idx_hit(input logic [`RCW_ADDR_W-1:0] a,
                                     input logic [15:0] idx);
        idx_hit = (a == {idx, 2'b00});
    endfunction

    // Any decoded register
    function automatic logic mapped(input logic [`RCW_ADDR_W-1:0] a);
        mapped = idx_hit(a, `RCW_IDX_CONFIG) || idx_hit(a, `RCW_IDX_STATUS)
            || idx_hit(a, `RCW_IDX_CLEAR);
    endfunction

    // ********************************
    // Decode
    // ********************************
    logic slow_tick;
    logic wr_fire;
    logic wr_clear;
    logic wr_cfg;
    logic wr_sts;
    logic wd_off;
    logic cnt_step;
    logic overflow;
    logic por_clear;
    logic stop_enter;
    logic hv_any;
    logic mon_entry;

    assign cfg.rate_sel = cfg_q[`RCW_CFG_RATE];
    assign cfg.stop_dis = cfg_q[`RCW_CFG_STOP_DIS];
    assign cfg.disable_wd = cfg_q[`RCW_CFG_DISABLE];
    // Slow clock is only a sampled level; stop gates it off
    assign slow_tick = slow_internal_clock && !slow_prev_q && !stop_q;
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
    assign wr_clear = wr_fire && idx_hit(aw_addr_q, `RCW_IDX_CLEAR);
    assign wr_cfg = wr_fire && idx_hit(aw_addr_q, `RCW_IDX_CONFIG) && w_strb_q[0];
    assign wr_sts = wr_fire && idx_hit(aw_addr_q, `RCW_IDX_STATUS) && w_strb_q[0];
    assign hv_any = mode_pins.irq_test_hv || mode_pins.rst_test_hv;
    assign mon_entry = mode_pins.monitor_mode && !mon_prev_q;
    // Every disable source; wait mode is not one of them
    assign wd_off = cfg.disable_wd
        || (mon_hv_q && hv_any)
        || blank_q
        || (mode_pins.break_state && mode_pins.rst_test_hv);
    // Short period wraps the counter off prescaler bit 6
    assign cnt_step = slow_tick && (cfg.rate_sel
        ? (pre_q[6:0] == 7'(`RCW_PRE_FAST))
        : (pre_q == `RCW_PRE_SLOW));
    assign overflow = cnt_step && (&cnt_q) && !wd_off && (rst_st_q == RCW_RUN);
    assign por_clear = slow_tick && !por_done_q && (por_cnt_q == 13'(POR_CYC - 1));
    assign stop_enter = stop_exec && !cfg.stop_dis;

    // ********************************
    // Slow clock edge and mode latches
    // ********************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            slow_prev_q <= 1'b0;
            mon_prev_q <= 1'b0;
        end
        else if (clk_en)
        begin
            slow_prev_q <= slow_internal_clock;
            mon_prev_q <= mode_pins.monitor_mode;
        end
    end

    // Test-voltage monitor disable lasts while a pin holds it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mon_hv_q <= 1'b0;
        else if (clk_en)
        begin
            if (mon_entry && mode_pins.irq_test_hv)
                mon_hv_q <= 1'b1;
            else if (!hv_any)
                mon_hv_q <= 1'b0;
        end
    end

    // Blank-vector entry: only the power-up reset releases it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            blank_q <= 1'b0;
        else if (clk_en && mon_entry && !mode_pins.irq_test_hv)
            blank_q <= 1'b1;
    end

    // Power-up delay, counted in slow cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            por_cnt_q <= 13'h0000;
            por_done_q <= 1'b0;
        end
        else if (clk_en && slow_tick && !por_done_q)
        begin
            por_cnt_q <= por_cnt_q + 13'h0001;
            por_done_q <= por_clear;
        end
    end

    // ********************************
    // Stop handling
    // ********************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            stop_q <= 1'b0;
            illegal_q <= 1'b0;
        end
        else if (clk_en)
        begin
            illegal_q <= stop_exec && cfg.stop_dis;
            if (stop_enter)
                stop_q <= 1'b1;
            else if (stop_wake)
                stop_q <= 1'b0;
        end
    end

    // ********************************
    // Prescaler and counter
    // ********************************
    // Clears take priority over counting
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pre_q <= '0;
        else if (clk_en)
        begin
            if (internal_reset || rst_st_q == RCW_PULL || wd_off)
                pre_q <= '0;
            else if (stop_enter || vector_fetch || por_clear)
                pre_q <= '0;
            else if (wr_clear)
                pre_q <= pre_q & PRE_W'(`RCW_PRE_KEEP);
            else if (slow_tick)
                pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_q <= '0;
        else if (clk_en)
        begin
            if (internal_reset || rst_st_q == RCW_PULL || wd_off || wr_clear)
                cnt_q <= '0;
            else if (cnt_step)
                cnt_q <= cnt_q + 1'b1;
        end
    end

    // ********************************
    // Reset pulse and cause flag
    // ********************************
    // Only a system reset leaves the block, no interrupt
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_st_q <= RCW_RUN;
            pull_cnt_q <= 5'h00;
            rst_n_q <= 1'b1;
        end
        else if (clk_en)
        begin
            case (rst_st_q)
                RCW_RUN:
                begin
                    if (overflow)
                    begin
                        rst_st_q <= RCW_PULL;
                        rst_n_q <= 1'b0;
                        pull_cnt_q <= 5'h00;
                    end
                end
                RCW_PULL:
                begin
                    if (slow_tick)
                    begin
                        pull_cnt_q <= pull_cnt_q + 5'h01;
                        if (pull_cnt_q == 5'(`RCW_RST_SLOW_CYC - 1))
                        begin
                            rst_st_q <= RCW_RUN;
                            rst_n_q <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    rst_st_q <= RCW_RUN;
                    rst_n_q <= 1'b1;
                end
            endcase
        end
    end

    // Set beats a same-cycle software clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flag_q <= 1'b0;
        else if (clk_en)
        begin
            if (overflow)
                flag_q <= 1'b1;
            else if (wr_sts && w_data_q[`RCW_STS_WDOG])
                flag_q <= 1'b0;
        end
    end

    // Configuration byte; reset clears rate select
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cfg_q <= `RCW_CFG_RESET;
        else if (clk_en && wr_cfg)
            cfg_q <= w_data_q[7:0];
    end

    // ********************************
    // AXI4-Lite write channel
    // ********************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= `RCW_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && awready_q)
            begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                awready_q <= 1'b0;
            end
            if (s_axi_wvalid && wready_q)
            begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                wready_q <= 1'b0;
            end
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= mapped(aw_addr_q) ? `RCW_RESP_OKAY : `RCW_RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // ********************************
    // AXI4-Lite read channel
    // ********************************
    // Clear location holds no state, it shows the vector byte
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RCW_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && arready_q)
            begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rresp_q <= mapped(s_axi_araddr) ? `RCW_RESP_OKAY : `RCW_RESP_SLVERR;
                if (idx_hit(s_axi_araddr, `RCW_IDX_CLEAR))
                    rdata_q <= {24'h00_0000, reset_vector_lo};
                else if (idx_hit(s_axi_araddr, `RCW_IDX_CONFIG))
                    rdata_q <= {24'h00_0000, cfg_q};
                else if (idx_hit(s_axi_araddr, `RCW_IDX_STATUS))
                    rdata_q <= {31'h0000_0000, flag_q};
                else
                    rdata_q <= 32'h0000_0000;
            end
            else if (rvalid_q && s_axi_rready)
            begin
                rvalid_q <= 1'b0;
                arready_q <= 1'b1;
            end
        end
    end

    // Outputs straight from flops
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign wdog_reset_n = rst_n_q;
    assign illegal_op_reset = illegal_q;

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_clear_write;
        clk_en && wr_clear && !internal_reset;
    endsequence

    sequence s_counter_gone;
        ##1 cnt_q == '0;
    endsequence

    a_clear_restart: assert property (s_clear_write |-> s_counter_gone)
        else $error("clear write did not zero counter");
    a_overflow_pull: assert property (clk_en && overflow |=> !wdog_reset_n && flag_q)
        else $error("overflow did not pull reset and set flag");
    a_pull_holds: assert property (!wdog_reset_n && !(clk_en && slow_tick) |=> !wdog_reset_n)
        else $error("reset pulse ended off a slow edge");
    a_internal_clear: assert property (clk_en && internal_reset |=> pre_q == '0 && cnt_q == '0)
        else $error("internal reset left counts");
    a_stop_clear: assert property (clk_en && stop_enter |=> pre_q == '0 && stop_q)
        else $error("stop did not clear prescaler");
    a_fetch_clear: assert property (clk_en && vector_fetch |=> pre_q == '0)
        else $error("vector fetch left prescaler");
    a_por_clear: assert property (clk_en && por_clear |=> pre_q == '0)
        else $error("power-up clear left prescaler");
    a_stop_illegal: assert property (clk_en && stop_exec && cfg.stop_dis |=> illegal_op_reset)
        else $error("disabled stop gave no illegal opcode reset");
    a_off_no_reset: assert property (wd_off && wdog_reset_n |=> wdog_reset_n)
        else $error("disabled watchdog pulled reset");
    a_read_vector: assert property (clk_en && s_axi_arvalid && arready_q
        && idx_hit(s_axi_araddr, `RCW_IDX_CLEAR)
        |=> s_axi_rdata == {24'h00_0000, $past(reset_vector_lo)})
        else $error("clear location read wrong byte");
    a_stopped_frozen: assert property (stop_q && clk_en && !internal_reset
        && !wd_off && !wr_clear |=> $stable(cnt_q))
        else $error("counter moved while stopped");
endmodule

// File: tb/rcw_sys_model.sv
module rcw_sys_model
#(
    parameter logic [7:0] VEC = 8'h5a
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Watchdog side
    input wire logic wdog_reset_n,
    output logic slow_internal_clock,
    output logic [7:0] reset_vector_lo,
    output logic [7:0] pulse_len
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_q;
    logic wd_q;

    // Vector byte that shares the clear location
    assign reset_vector_lo = VEC;

    // Free-running oscillator, one slow edge every two bus cycles
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            slow_internal_clock <= 1'h0;
        else
            slow_internal_clock <= ~slow_internal_clock;
    end

    // Slow edges seen while the reset line is held low
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= 8'h00;
            wd_q <= 1'h1;
            pulse_len <= 8'h00;
        end
        else
        begin
            wd_q <= wdog_reset_n;
            if (!wdog_reset_n)
                cnt_q <= cnt_q + {7'h00, slow_internal_clock};
            else
                cnt_q <= 8'h00;
            if (wdog_reset_n && !wd_q)
                pulse_len <= cnt_q;
        end
    end
endmodule

// File: tb/tb_top.sv
`include "rcw_regs.svh"
`define CHK(a, e) \
    begin \
        num_checks++; \
        if ((a) !== (e)) \
        begin \
            fail_count++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); \
        end \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ********************************
    // Bench signals
    // ********************************
    localparam logic [17:0] CFG = {`RCW_IDX_CONFIG, 2'h0};
    localparam logic [17:0] STS = {`RCW_IDX_STATUS, 2'h0};
    localparam logic [17:0] CLR = {`RCW_IDX_CLEAR, 2'h0};
    localparam logic [17:0] BAD = 18'h00008;
    localparam logic [7:0] VEC = 8'h5a;
    localparam logic [1:0] OK = `RCW_RESP_OKAY;
    int fail_count = 0;
    int num_checks = 0;
    int at;
    logic [31:0] d;
    logic [1:0] r;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [17:0] s_axi_awaddr = '0;
    logic [17:0] s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic internal_reset = 1'h0, vector_fetch = 1'h0;
    logic clk_en = 1'h1;
    logic stop_exec = 1'h0, stop_wake = 1'h0;
    rcw_pkg::rcw_mode_t mode_pins = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic slow_internal_clock, wdog_reset_n, illegal_op_reset;
    logic [7:0] reset_vector_lo, pulse_len;

    // 125 MHz bus clock
    always #4 aclk = ~aclk;

    // Short power-on wait keeps the run brief
    rcw_runaway_watchdog #(.POR_CYC(8)) DUT
    (
        .aclk, .aresetn, .clk_en,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .slow_internal_clock, .internal_reset, .vector_fetch, .reset_vector_lo,
        .stop_exec, .stop_wake, .mode_pins, .wdog_reset_n, .illegal_op_reset
    );

    rcw_sys_model #(.VEC(VEC)) u_sys
    (
        .aclk, .aresetn, .wdog_reset_n, .slow_internal_clock, .reset_vector_lo, .pulse_len
    );

    // ********************************
    // Bus tasks
    // ********************************
    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [17:0] a, input logic [31:0] v, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        `CHK(n > 1, 1'h1)
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            n++;
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        `CHK(n > 1, 1'h1)
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask

    // Runs n slow edges, notes the first one with reset low
    task automatic run(input int n, output int t);
        t = -1;
        for (int i = 0; i < 2 * n; i++)
        begin
            @(posedge aclk);
            if (wdog_reset_n !== 1'h1 && t < 0)
                t = i / 2;
        end
    endtask

    task automatic hold(input logic [3:0] m);
        mode_pins <= m;
        repeat (20) @(posedge aclk);
        mode_pins <= '0;
        @(posedge aclk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ********************************
    // Tests
    // ********************************
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(CFG, 32'h0, OK);
        rd(STS, 32'h0, OK);
        rd(CLR, {24'h0, VEC}, OK);
        rd(BAD, 32'h0, `RCW_RESP_SLVERR);
        wr(BAD, 32'h81, `RCW_RESP_SLVERR);
        rd(CFG, 32'h0, OK);
        wr(CFG, 32'h80, OK);
        rd(CFG, 32'h80, OK);
        wr(CLR, 32'h0, OK);
        run(8400, at);
        `CHK(at >= 8150 && at <= 8200, 1'h1)
        `CHK(pulse_len, 8'h20)
        rd(STS, 32'h1, OK);
        wr(STS, 32'h1, OK);
        rd(STS, 32'h0, OK);
        // Each hold below must restart the period, else two spans overflow
        vector_fetch <= 1'h1;
        @(posedge aclk);
        vector_fetch <= 1'h0;
        internal_reset <= 1'h1;
        @(posedge aclk);
        internal_reset <= 1'h0;
        for (int k = 0; k < 5; k++)
        begin
            run(4300, at);
            `CHK(at, -1)
            case (k)
                0: wr(CLR, 32'hff, OK);
                1:
                begin
                    wr(CFG, 32'h81, OK);
                    wr(CFG, 32'h80, OK);
                end
                2: hold(4'h3);
                3: hold(4'hc);
                default: ;
            endcase
        end
        // Stopped long enough that a running count would overflow
        stop_exec <= 1'h1;
        @(posedge aclk);
        stop_exec <= 1'h0;
        run(4000, at);
        `CHK(at, -1)
        stop_wake <= 1'h1;
        @(posedge aclk);
        stop_wake <= 1'h0;
        run(4200, at);
        `CHK(at >= 3930 && at <= 4010, 1'h1)
        wr(CFG, 32'h82, OK);
        // Frozen enable must swallow a stop, so no reset pulse
        clk_en <= 1'h0;
        stop_exec <= 1'h1;
        @(posedge aclk);
        stop_exec <= 1'h0;
        @(posedge aclk);
        `CHK(illegal_op_reset, 1'h0)
        clk_en <= 1'h1;
        stop_exec <= 1'h1;
        @(posedge aclk);
        stop_exec <= 1'h0;
        @(posedge aclk);
        `CHK(illegal_op_reset, 1'h1)
        @(posedge aclk);
        `CHK(illegal_op_reset, 1'h0)
        hold(4'h8);
        run(8600, at);
        `CHK(at, -1)
        results();
    end

    // Hang guard, a little above the expected run length
    initial
    begin
        repeat (100000) @(posedge aclk);
        fail_count++;
        results();
    end
endmodule
